/* File: common/lmc_pkg.sv */
// package of constants and types for the transceiver mode controller
package lmc_pkg;
    // clock period in ns
    localparam int CLK_PERIOD_NS = 10;
    // least bus low time for wake-up, in us
    localparam int WAKE_DOM_US = 30;
    // least sleep control high time for normal entry, in us
    localparam int GOTONORM_US = 2;
    // least sleep control low time for sleep entry, in us
    localparam int GOTOSLEEP_US = 2;
    localparam int WAKE_DOM_CYC = (WAKE_DOM_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GOTONORM_CYC = (GOTONORM_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GOTOSLEEP_CYC = (GOTOSLEEP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 16;

    // modes, gray coded along reset, sleep, standby, normal
    typedef enum logic [1:0] {
        LMC_RESET = 2'h0,
        LMC_SLEEP = 2'h1,
        LMC_STANDBY = 2'h3,
        LMC_NORMAL = 2'h2
    } lmc_mode_t;
endpackage : lmc_pkg

/* File: hw/lmc_level_filter.sv */
// level filter: output goes high once a level has held for a set number of cycles and stays high while it holds
`timescale 1ns/100ps
`default_nettype none
module lmc_level_filter #(
    parameter int HOLD_CYC = 2
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_clear,
    input wire logic i_level,
    output logic o_held
);
    logic [lmc_pkg::CNT_W-1:0] cnt_ff;
    logic [lmc_pkg::CNT_W-1:0] nxt_cnt;
    logic held_ff;
    logic nxt_held;
    logic at_limit;

    // counter restarts whenever the level breaks
    assign at_limit = (cnt_ff == lmc_pkg::CNT_W'(HOLD_CYC - 1));
    assign nxt_cnt = (!i_level || i_clear) ? '0 : (held_ff ? cnt_ff : cnt_ff + 1'b1);
    assign nxt_held = i_level && !i_clear && (held_ff || at_limit);

    // count and held flag
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            cnt_ff <= '0;
            held_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            held_ff <= nxt_held;
        end
    end

    assign o_held = held_ff;
endmodule : lmc_level_filter
`default_nettype wire

/* File: hw/lmc_mode_ctrl.sv */
// mode controller of the single-wire bus transceiver
`timescale 1ns/100ps
`default_nettype none
module lmc_mode_ctrl (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_por, // supply below power-on threshold, synchronised
    input wire logic i_thermal_sd, // thermal shutdown flag, synchronised
    input wire logic i_sleep_ctl_n,
    input wire logic i_txd,
    input wire logic i_bus_in, // 1 recessive, 0 dominant
    output logic o_rxd_out, // open-drain receive output value (always 0)
    output logic o_rxd_oe, // high while pulling receive output low
    output logic o_bus_out, // bus driver value (always 0 = dominant)
    output logic o_bus_oe, // high while driving bus dominant
    output logic o_tx_en, // transmitter enabled
    output logic [1:0] o_mode
);
    lmc_pkg::lmc_mode_t mode_ff;
    lmc_pkg::lmc_mode_t nxt_mode;
    logic slp_d_ff;
    logic bus_d_ff;
    logic wake_armed_ff;
    logic nxt_wake_armed;
    logic tx_en_ff;
    logic nxt_tx_en;
    logic rxd_oe_ff;
    logic nxt_rxd_oe;
    logic bus_oe_ff;
    logic nxt_bus_oe;
    logic slp_rise;
    logic slp_fall;
    logic bus_rise;
    logic wake_low_held;
    logic norm_held;
    logic sleep_held;
    logic wake_event;
    logic in_normal;
    logic filt_clear;

    // edge detection on sleep control and bus
    assign slp_rise = i_sleep_ctl_n && !slp_d_ff;
    assign slp_fall = !i_sleep_ctl_n && slp_d_ff;
    assign bus_rise = i_bus_in && !bus_d_ff;
    assign in_normal = (mode_ff == lmc_pkg::LMC_NORMAL);
    assign filt_clear = i_por;

    // bus low time filter for remote wake-up
    lmc_level_filter #(
        .HOLD_CYC(lmc_pkg::WAKE_DOM_CYC)
    ) u_wake_filt (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_clear(filt_clear),
        .i_level(!i_bus_in && (mode_ff == lmc_pkg::LMC_SLEEP)),
        .o_held(wake_low_held)
    );

    // sleep control high time for normal entry
    lmc_level_filter #(
        .HOLD_CYC(lmc_pkg::GOTONORM_CYC)
    ) u_norm_filt (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_clear(filt_clear),
        .i_level(i_sleep_ctl_n && !in_normal),
        .o_held(norm_held)
    );

    // sleep control low time for sleep entry
    lmc_level_filter #(
        .HOLD_CYC(lmc_pkg::GOTOSLEEP_CYC)
    ) u_sleep_filt (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_clear(filt_clear),
        .i_level(!i_sleep_ctl_n && in_normal),
        .o_held(sleep_held)
    );

    // wake-up: falling edge, held low, then rising edge
    assign nxt_wake_armed = (mode_ff == lmc_pkg::LMC_SLEEP) && !i_por
        && !i_bus_in ? (wake_armed_ff || wake_low_held) : 1'b0;
    assign wake_event = wake_armed_ff && bus_rise;

    // mode sequencing
    always_comb begin
        nxt_mode = mode_ff;
        if (i_por) begin
            nxt_mode = lmc_pkg::LMC_RESET;
        end else begin
            unique case (mode_ff)
                lmc_pkg::LMC_RESET: begin
                    nxt_mode = lmc_pkg::LMC_SLEEP;
                end
                lmc_pkg::LMC_SLEEP: begin
                    if (norm_held) begin
                        nxt_mode = lmc_pkg::LMC_NORMAL;
                    end else if (wake_event) begin
                        nxt_mode = lmc_pkg::LMC_STANDBY;
                    end
                end
                lmc_pkg::LMC_STANDBY: begin
                    if (norm_held) begin
                        nxt_mode = lmc_pkg::LMC_NORMAL;
                    end
                end
                lmc_pkg::LMC_NORMAL: begin
                    if (sleep_held) begin
                        nxt_mode = lmc_pkg::LMC_SLEEP;
                    end
                end
            endcase
        end
    end

    // transmitter enable: only in normal, after txd high, never under thermal flag
    always_comb begin
        nxt_tx_en = tx_en_ff;
        if (i_por || i_thermal_sd || nxt_mode != lmc_pkg::LMC_NORMAL) begin
            nxt_tx_en = 1'b0;
        end else if (!in_normal || slp_fall || !i_sleep_ctl_n) begin
            nxt_tx_en = 1'b0;
        end else if (i_txd) begin
            nxt_tx_en = 1'b1;
        end
    end

    // bus drive: dominant while transmit low and enabled
    assign nxt_bus_oe = nxt_tx_en && !i_txd;

    // receive output pull-down by mode
    always_comb begin
        nxt_rxd_oe = 1'b0;
        unique case (nxt_mode)
            lmc_pkg::LMC_RESET: nxt_rxd_oe = 1'b0;
            lmc_pkg::LMC_SLEEP: nxt_rxd_oe = 1'b0;
            lmc_pkg::LMC_STANDBY: nxt_rxd_oe = !slp_rise;
            lmc_pkg::LMC_NORMAL: nxt_rxd_oe = !i_bus_in;
        endcase
    end

    // state registers
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            mode_ff <= lmc_pkg::LMC_RESET;
            slp_d_ff <= 1'b0;
            bus_d_ff <= 1'b1;
            wake_armed_ff <= 1'b0;
        end else begin
            mode_ff <= nxt_mode;
            slp_d_ff <= i_sleep_ctl_n;
            bus_d_ff <= i_bus_in;
            wake_armed_ff <= nxt_wake_armed;
        end
    end

    // output registers
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            tx_en_ff <= 1'b0;
            bus_oe_ff <= 1'b0;
            rxd_oe_ff <= 1'b0;
        end else begin
            tx_en_ff <= nxt_tx_en;
            bus_oe_ff <= nxt_bus_oe;
            rxd_oe_ff <= nxt_rxd_oe;
        end
    end

    assign o_rxd_out = 1'b0;
    assign o_rxd_oe = rxd_oe_ff;
    assign o_bus_out = 1'b0;
    assign o_bus_oe = bus_oe_ff;
    assign o_tx_en = tx_en_ff;
    assign o_mode = mode_ff;
endmodule : lmc_mode_ctrl
`default_nettype wire

/* File: verification/lmc_ctrl_model.sv */
// bus controller model: receive line pull-up seen by the controller
`timescale 1ns/100ps
`default_nettype none
module lmc_ctrl_model (
    input wire logic i_rxd_out,
    input wire logic i_rxd_oe,
    output logic o_rxd_line
);
    // device only pulls low, the pull-up gives the high level
    assign o_rxd_line = i_rxd_oe ? i_rxd_out : 1'b1;
endmodule : lmc_ctrl_model
`default_nettype wire

/* File: verification/lmc_monitor.sv */
// checker of mode sequencing and driver gating at the controller ports
`timescale 1ns/100ps
`default_nettype none
module lmc_monitor (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_por,
    input wire logic i_thermal_sd,
    input wire logic i_sleep_ctl_n,
    input wire logic i_txd,
    input wire logic i_bus_in,
    input wire logic o_rxd_out,
    input wire logic o_rxd_oe,
    input wire logic o_bus_out,
    input wire logic o_bus_oe,
    input wire logic o_tx_en,
    input wire logic [1:0] o_mode
);
    logic rst_q_ff;

    // reset level one edge late, so the edge that releases reset stays quiet
    always_ff @(posedge i_ref_clk) begin
        rst_q_ff <= i_rst_b;
    end

    // one clock domain, disabled while reset is low and on the releasing edge
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b || !rst_q_ff);
    reset_quiet_a: assert property (o_mode == 2'h0 |-> !(o_rxd_oe | o_bus_oe | o_tx_en))
        else $error("driver active in reset mode");
    por_enter_a: assert property (i_por |=> o_mode == 2'h0)
        else $error("power-on flag did not force reset mode");
    por_exit_a: assert property (o_mode == 2'h0 && !i_por |=> o_mode == 2'h1)
        else $error("reset mode not left to sleep");
    sleep_quiet_a: assert property (o_mode == 2'h1 |-> !(o_tx_en | o_rxd_oe | o_bus_oe))
        else $error("driver active in sleep mode");
    standby_flag_a: assert property (o_mode == 2'h3 && !i_sleep_ctl_n |-> o_rxd_oe && !o_tx_en)
        else $error("standby flag missing");
    flag_clear_a: assert property ($rose(i_sleep_ctl_n) && o_mode == 2'h3 |=> ##[0:1] !o_rxd_oe)
        else $error("wake flag not released on sleep control rise");
    tx_init_a: assert property ($rose(o_tx_en) |-> $past(i_txd) && o_mode == 2'h2)
        else $error("transmitter enabled without transmit high");
    thermal_off_a: assert property (i_thermal_sd |=> !o_tx_en && !o_bus_oe)
        else $error("transmitter on during thermal shutdown");
    normal_rx_a: assert property (o_mode == 2'h2 && $past(o_mode) == 2'h2 |-> o_rxd_oe == !$past(i_bus_in))
        else $error("receive output does not follow bus");
    sleep_fall_a: assert property ($fell(i_sleep_ctl_n) && o_mode == 2'h2 |=> !o_tx_en)
        else $error("transmit path kept after sleep control fall");
    bus_drive_a: assert property (o_bus_oe == (o_tx_en && !$past(i_txd)))
        else $error("bus drive does not match transmit input");
endmodule : lmc_monitor
bind lmc_mode_ctrl lmc_monitor u_mon (.*);
`default_nettype wire

/* File: verification/testbench.sv */
// self-checking bench of the transceiver mode controller
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic i_ref_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_por = 1'b0;
    logic i_thermal_sd = 1'b0;
    logic i_sleep_ctl_n = 1'b0;
    logic i_txd = 1'b1;
    logic bus_ext = 1'b1;
    logic o_rxd_out, o_rxd_oe, o_bus_out, o_bus_oe, o_tx_en, rxd_line;
    logic [1:0] o_mode;
    int failures = 0;
    int n_checks = 0;
    // bus line: recessive by termination unless a driver pulls it low
    wire logic bus_line = o_bus_oe ? o_bus_out : bus_ext;
    always #5 i_ref_clk = ~i_ref_clk;
    lmc_mode_ctrl DUT (.*, .i_bus_in(bus_line));
    lmc_ctrl_model u_ctl (.i_rxd_out(o_rxd_out), .i_rxd_oe(o_rxd_oe), .o_rxd_line(rxd_line));
    task summarize;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : summarize
    task chk(input logic [1:0] got, input logic [1:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task wt(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask : wt
    // bounded wait for a mode, a miss ends the run
    task wm(input logic [1:0] m, input int lim);
        for (int i = 0; i < lim && o_mode !== m; i++) @(negedge i_ref_clk);
        chk(o_mode, m);
        if (o_mode !== m) summarize();
    endtask : wm
    task t_reset;
        wt(9);
        chk(o_mode, 2'h0);
        chk(o_tx_en | o_rxd_oe | o_bus_oe, 2'h0);
        @(posedge i_ref_clk) i_rst_b <= 1'b1;
        wm(2'h1, 4);
    endtask : t_reset
    task t_wake;
        @(posedge i_ref_clk) bus_ext <= 1'b0;
        wt(100);
        @(posedge i_ref_clk) bus_ext <= 1'b1;
        wt(5);
        chk(o_mode, 2'h1);
        @(posedge i_ref_clk) bus_ext <= 1'b0;
        wt(3005);
        chk(o_mode, 2'h1);
        @(posedge i_ref_clk) bus_ext <= 1'b1;
        wm(2'h3, 4);
        chk(rxd_line, 2'h0);
    endtask : t_wake
    task t_normal;
        @(posedge i_ref_clk) i_txd <= 1'b0;
        i_sleep_ctl_n <= 1'b1;
        wm(2'h2, 260);
        wt(5);
        chk(o_tx_en, 2'h0);
        @(posedge i_ref_clk) i_txd <= 1'b1;
        wt(3);
        chk(o_tx_en, 2'h1);
        @(posedge i_ref_clk) i_txd <= 1'b0;
        wt(3);
        chk(bus_line, 2'h0);
        chk(rxd_line, 2'h0);
        @(posedge i_ref_clk) i_txd <= 1'b1;
        wt(3);
        chk(rxd_line, 2'h1);
    endtask : t_normal
    task t_thermal;
        @(posedge i_ref_clk) i_thermal_sd <= 1'b1;
        wt(2);
        chk(o_tx_en, 2'h0);
        @(posedge i_ref_clk) i_thermal_sd <= 1'b0;
        i_txd <= 1'b0;
        wt(5);
        chk(bus_line, 2'h1);
        @(posedge i_ref_clk) i_txd <= 1'b1;
        wt(3);
        chk(o_tx_en, 2'h1);
    endtask : t_thermal
    task t_sleep;
        @(posedge i_ref_clk) i_sleep_ctl_n <= 1'b0;
        wt(2);
        chk(o_tx_en, 2'h0);
        wm(2'h1, 260);
        @(posedge i_ref_clk) i_sleep_ctl_n <= 1'b1;
        wt(50);
        @(posedge i_ref_clk) i_sleep_ctl_n <= 1'b0;
        wt(300);
        chk(o_mode, 2'h1);
    endtask : t_sleep
    task t_por;
        @(posedge i_ref_clk) i_sleep_ctl_n <= 1'b1;
        i_por <= 1'b1;
        wt(2);
        chk(o_mode, 2'h0);
        wt(300);
        chk(o_mode, 2'h0);
        @(posedge i_ref_clk) i_por <= 1'b0;
        wm(2'h1, 3);
    endtask : t_por
    initial begin
        t_reset();
        t_wake();
        t_normal();
        t_thermal();
        t_sleep();
        t_por();
        summarize();
    end
endmodule : testbench
`default_nettype wire
